// File: design/urx_channel.sv
// one uart channel: receiver, receive fifo, line and modem status, interrupt enables and priority
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "urx_map.svh"
module urx_channel (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclken,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_pin,
	input wire urx_pkg::urx_modem_type modem_pins_n,
	input wire logic thr_empty,
	input wire logic tsr_empty,
	input wire logic tx_below_trig,
	input wire logic xoff_seen,
	output logic rts_n,
	output logic tx_write,
	output logic [7:0] tx_data,
	output logic irq
);
	import urx_pkg::*;

	logic [7:0] interrupt_enable; // interrupt_enable
	logic [7:0] line_control_reg; // line_control_reg
	logic [7:0] mcr; // modem control: rts and 8x select
	logic [7:0] enhanced_feature_reg; // enhanced_feature_reg
	logic [7:0] feature_control_reg; // feature_control_reg
	logic [7:0] rxtrg; // programmable receive trigger
	logic [7:0] dll; // divisor low byte
	logic [7:0] divisor_high_byte; // divisor_high_byte
	logic fifo_en; // fifos enabled by fifo_control_reg
	logic [1:0] rx_trig_sel; // fixed trigger selector
	logic acc, wr, rd, dlab, map_ok;
	logic rhr_rd, lsr_rd, msr_rd, isr_rd, thr_wr, fifo_clr;
	logic [7:0] next_rdata; // read mux result
	logic [4:0] sync_q; // synced {rx, modem pins}
	logic rx_s, rx_prev, rx_fall;
	urx_modem_type ms_pin, ms_prev; // synced modem pins and last value
	logic [15:0] baud_cnt; // divisor down-counter
	logic tick; // one oversampling clock
	logic [4:0] bit_last, half_last, os_cnt, bt_cnt;
	urx_state_type state;
	logic [3:0] bit_idx, wl;
	logic [7:0] shreg; // rx_shift_reg
	logic par_bit, perr, rx_push, push_ok, pop, fifo_full;
	urx_rx_entry_type rx_entry, head, nxt_head;
	urx_rx_entry_type rx_mem [0:63]; // receive fifo storage
	logic [5:0] wr_ptr, rd_ptr;
	logic [6:0] level, err_cnt, fifo_cap;
	logic [7:0] trig; // active receive trigger level
	logic rx_avail, overrun, lsr_int, lsr_set;
	logic [5:0] tmo_bits, tmo_limit; // idle time in bit times
	logic bit_tick, tmo_clr, tmo_set, tmo;
	logic tx_src, tx_prev, below_prev, txrdy, tx_set;
	logic [3:0] delta, delta_set; // modem delta bits
	logic rts_prev, flow_set, flow_f, xoff_f;
	logic [6:0] pend; // pending sources, index 0 highest
	logic [2:0] cur_idx, next_idx; // serviced source held until cleared
	logic [7:0] lsr_val;

	// register index decode, used for every register
	function automatic logic hit(input logic [31:0] a, input logic [3:0] idx);
		hit = (a[31:6] == {26{1'b0}}) && (a[5:2] == idx) && (a[1:0] == 2'b00);
	endfunction
	// any error flag on a fifo entry
	function automatic logic has_err(input urx_rx_entry_type e);
		has_err = e.brk || e.frm || e.par;
	endfunction
	// highest-priority pending source
	function automatic logic [2:0] pick(input logic [6:0] p);
		pick = `URX_IDX_NONE;
		for (int i = 6; i >= 0; i--) begin
			if (p[i]) begin
				pick = 3'(i);
			end
		end
	endfunction
	// six-bit status code of a source
	function automatic logic [5:0] code_of(input logic [2:0] i);
		case (i)
			3'h0: code_of = `URX_CODE_LSR;
			3'h1: code_of = `URX_CODE_RXRDY;
			3'h2: code_of = `URX_CODE_RXTMO;
			3'h3: code_of = `URX_CODE_TXRDY;
			3'h4: code_of = `URX_CODE_MSR;
			3'h5: code_of = `URX_CODE_XOFF;
			3'h6: code_of = `URX_CODE_FLOW;
			default: code_of = `URX_CODE_NONE;
		endcase
	endfunction

	// bus strobes: effects land on the edge where pready is sampled high
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign dlab = line_control_reg[`URX_LCR_DLAB];
	assign rhr_rd = rd && hit(paddr, `URX_IDX_RHR) && !dlab;
	assign lsr_rd = rd && hit(paddr, `URX_IDX_LSR);
	assign msr_rd = rd && hit(paddr, `URX_IDX_MSR);
	assign isr_rd = rd && hit(paddr, `URX_IDX_ISR);
	assign thr_wr = wr && hit(paddr, `URX_IDX_RHR) && !dlab;
	assign fifo_clr = wr && hit(paddr, `URX_IDX_ISR) && pwdata[`URX_FCR_EN] && pwdata[`URX_FCR_RXCLR];

	// read mux; undecoded addresses answer with pslverr
	always_comb begin
		next_rdata = 8'h00;
		map_ok = 1'b1;
		if (hit(paddr, `URX_IDX_RHR)) begin
			next_rdata = dlab ? dll : (level != 7'h00 ? head.data : 8'h00);
		end else if (hit(paddr, `URX_IDX_IER)) begin
			next_rdata = dlab ? divisor_high_byte : interrupt_enable;
		end else if (hit(paddr, `URX_IDX_ISR)) begin
			next_rdata = {fifo_en, fifo_en, code_of(cur_idx)};
		end else if (hit(paddr, `URX_IDX_LCR)) begin
			next_rdata = line_control_reg;
		end else if (hit(paddr, `URX_IDX_MCR)) begin
			next_rdata = mcr;
		end else if (hit(paddr, `URX_IDX_LSR)) begin
			next_rdata = lsr_val;
		end else if (hit(paddr, `URX_IDX_MSR)) begin
			next_rdata = {~ms_pin.cd_n, ~ms_pin.ri_n, ~ms_pin.dsr_n, ~ms_pin.cts_n, delta};
		end else if (hit(paddr, `URX_IDX_FEATURE_CONTROL_REG)) begin
			next_rdata = feature_control_reg;
		end else if (hit(paddr, `URX_IDX_EFR)) begin
			next_rdata = enhanced_feature_reg;
		end else if (hit(paddr, `URX_IDX_RXCNT)) begin
			next_rdata = {1'b0, level};
		end else begin
			map_ok = 1'b0;
		end
	end

	// one wait state so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (pclken) begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				prdata <= pwrite ? 32'h00000000 : {24'h000000, next_rdata};
				pslverr <= !map_ok;
			end
		end
	end

	// register writes; divisors only while the latch bit is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_enable <= `URX_IER_RESET;
			line_control_reg <= `URX_LCR_RESET;
			mcr <= `URX_REG_RESET;
			enhanced_feature_reg <= `URX_REG_RESET;
			feature_control_reg <= `URX_REG_RESET;
			rxtrg <= `URX_REG_RESET;
			dll <= `URX_REG_RESET;
			divisor_high_byte <= `URX_REG_RESET;
			fifo_en <= 1'b0;
			rx_trig_sel <= 2'b00;
		end else if (pclken && wr) begin
			if (hit(paddr, `URX_IDX_RHR) && dlab) begin
				dll <= pwdata[7:0];
			end
			if (hit(paddr, `URX_IDX_IER)) begin
				if (dlab) begin
					divisor_high_byte <= pwdata[7:0];
				end else begin
					interrupt_enable <= pwdata[7:0] & `URX_IER_WMASK;
				end
			end
			if (hit(paddr, `URX_IDX_ISR)) begin
				fifo_en <= pwdata[`URX_FCR_EN];
				// other fifo control bits only take with the enable bit
				if (pwdata[`URX_FCR_EN]) begin
					rx_trig_sel <= pwdata[7:6];
				end
			end
			if (hit(paddr, `URX_IDX_LCR)) line_control_reg <= pwdata[7:0];
			if (hit(paddr, `URX_IDX_MCR)) mcr <= pwdata[7:0];
			if (hit(paddr, `URX_IDX_FEATURE_CONTROL_REG)) feature_control_reg <= pwdata[7:0];
			if (hit(paddr, `URX_IDX_EFR)) enhanced_feature_reg <= pwdata[7:0];
			if (hit(paddr, `URX_IDX_RXCNT)) rxtrg <= pwdata[7:0];
		end
	end

	// transmit byte handed to the transmitter, plus rts pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_write <= 1'b0;
			tx_data <= 8'h00;
			rts_n <= 1'b1;
			rts_prev <= 1'b1;
		end else if (pclken) begin
			tx_write <= thr_wr;
			if (thr_wr) begin
				tx_data <= pwdata[7:0];
			end
			rts_n <= ~mcr[`URX_MCR_RTS];
			rts_prev <= rts_n;
		end
	end

	// pins cross into pclk here; nothing reads the first stage
	urx_sync #(.WIDTH(5)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.ce(pclken),
		.d({rx_pin, modem_pins_n}),
		.q(sync_q)
	);
	assign rx_s = sync_q[4];
	assign ms_pin = urx_modem_type'(sync_q[3:0]);
	assign rx_fall = rx_prev && !rx_s;

	// oversampling clock from the divisor; zero behaves as one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_cnt <= 16'h0000;
			tick <= 1'b0;
			rx_prev <= 1'b1;
		end else if (pclken) begin
			rx_prev <= rx_s;
			tick <= (baud_cnt == 16'h0000);
			if (baud_cnt == 16'h0000) begin
				baud_cnt <= ({divisor_high_byte, dll} == 16'h0000) ? 16'h0000 : {divisor_high_byte, dll} - 16'h0001;
			end else begin
				baud_cnt <= baud_cnt - 16'h0001;
			end
		end
	end
	assign bit_last = (mcr[`URX_MCR_OS8] ? `URX_OS8_BIT : `URX_OS16_BIT) - 5'h01;
	assign half_last = (mcr[`URX_MCR_OS8] ? `URX_OS8_HALF : `URX_OS16_HALF) - 5'h01;
	assign wl = `URX_WL_BASE + {2'b00, line_control_reg[1:0]};
	// odd parity wants the xor of data and parity bit to be one
	assign perr = line_control_reg[`URX_LCR_PAR_EN] && ((^shreg) ^ par_bit ^ !line_control_reg[`URX_LCR_EVEN]);

	// receive sequencer; stop sampled at its centre, then idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= URX_IDLE;
			os_cnt <= 5'h00;
			bit_idx <= 4'h0;
			shreg <= 8'h00;
			par_bit <= 1'b0;
			rx_push <= 1'b0;
			rx_entry <= '0;
		end else if (pclken) begin
			rx_push <= 1'b0;
			case (state)
				URX_IDLE: begin
					if (rx_fall) begin
						state <= URX_START;
						os_cnt <= 5'h00;
						shreg <= 8'h00;
						par_bit <= 1'b0;
					end
				end
				URX_START: if (tick) begin
					if (os_cnt == half_last) begin
						os_cnt <= 5'h00;
						bit_idx <= 4'h0;
						// a glitch shorter than half a bit is dropped here
						state <= rx_s ? URX_IDLE : URX_DATA;
					end else begin
						os_cnt <= os_cnt + 5'h01;
					end
				end
				URX_DATA: if (tick) begin
					if (os_cnt == bit_last) begin
						os_cnt <= 5'h00;
						shreg[bit_idx[2:0]] <= rx_s;
						bit_idx <= bit_idx + 4'h1;
						if (bit_idx == wl - 4'h1) begin
							state <= line_control_reg[`URX_LCR_PAR_EN] ? URX_PARITY : URX_STOP;
						end
					end else begin
						os_cnt <= os_cnt + 5'h01;
					end
				end
				URX_PARITY: if (tick) begin
					if (os_cnt == bit_last) begin
						os_cnt <= 5'h00;
						par_bit <= rx_s;
						state <= URX_STOP;
					end else begin
						os_cnt <= os_cnt + 5'h01;
					end
				end
				URX_STOP: if (tick) begin
					if (os_cnt == bit_last) begin
						rx_push <= 1'b1;
						rx_entry.data <= shreg;
						rx_entry.frm <= !rx_s;
						rx_entry.par <= perr;
						rx_entry.brk <= (shreg == 8'h00) && !par_bit && !rx_s;
						state <= URX_IDLE;
					end else begin
						os_cnt <= os_cnt + 5'h01;
					end
				end
				default: state <= URX_IDLE;
			endcase
		end
	end

	// receive fifo; without fifo mode it holds a single character
	assign fifo_cap = fifo_en ? `URX_FIFO_CAP : `URX_NOFIFO_CAP;
	assign fifo_full = (level >= fifo_cap);
	assign push_ok = rx_push && !fifo_full;
	assign pop = rhr_rd && (level != 7'h00);
	assign head = rx_mem[rd_ptr];
	assign nxt_head = rx_mem[rd_ptr + 6'h01];
	always_ff @(posedge pclk) begin
		if (pclken && push_ok) begin
			rx_mem[wr_ptr] <= rx_entry;
		end
	end
	// pointers, level and count of errored entries
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= 6'h00;
			rd_ptr <= 6'h00;
			level <= 7'h00;
			err_cnt <= 7'h00;
		end else if (pclken) begin
			if (fifo_clr) begin
				wr_ptr <= 6'h00;
				rd_ptr <= 6'h00;
				level <= 7'h00;
				err_cnt <= 7'h00;
			end else begin
				wr_ptr <= wr_ptr + {5'h00, push_ok};
				rd_ptr <= rd_ptr + {5'h00, pop};
				level <= level + {6'h00, push_ok} - {6'h00, pop};
				err_cnt <= err_cnt + {6'h00, push_ok && has_err(rx_entry)} - {6'h00, pop && has_err(head)};
			end
		end
	end
	// head flags only describe the head; summary counts all
	assign lsr_val = {err_cnt != 7'h00, thr_empty && tsr_empty, thr_empty,
		(level != 7'h00) && head.brk, (level != 7'h00) && head.frm,
		(level != 7'h00) && head.par, overrun, level != 7'h00};

	// line status interrupt: on arrival and again at the head
	assign lsr_set = (push_ok && has_err(rx_entry)) || (rx_push && fifo_full) ||
		(pop && (level > 7'h01) && has_err(nxt_head));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun <= 1'b0;
			lsr_int <= 1'b0;
		end else if (pclken) begin
			// a new event in the read cycle survives the read
			if (rx_push && fifo_full) overrun <= 1'b1;
			else if (lsr_rd) overrun <= 1'b0;
			if (lsr_set) lsr_int <= 1'b1;
			else if (lsr_rd) lsr_int <= 1'b0;
		end
	end

	// receive trigger: fixed table or the programmable level
	assign trig = (feature_control_reg[7:6] == 2'b11) ? rxtrg :
		(rx_trig_sel == 2'b00) ? 8'h01 : (rx_trig_sel == 2'b01) ? 8'h04 :
		(rx_trig_sel == 2'b10) ? 8'h08 : 8'h0E;
	assign rx_avail = fifo_en ? ({1'b0, level} >= trig) : (level != 7'h00);

	// idle timer in bit times; any line or fifo activity restarts it
	assign tmo_limit = {wl, 2'b00} + `URX_TMO_EXTRA;
	assign bit_tick = tick && (bt_cnt == bit_last);
	assign tmo_clr = !fifo_en || (level == 7'h00) || rx_avail || push_ok || pop || (state != URX_IDLE);
	assign tmo_set = bit_tick && !tmo_clr && (tmo_bits == tmo_limit - 6'h01);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bt_cnt <= 5'h00;
			tmo_bits <= 6'h00;
			tmo <= 1'b0;
		end else if (pclken) begin
			if (tick) bt_cnt <= (bt_cnt == bit_last) ? 5'h00 : bt_cnt + 5'h01;
			if (tmo_clr) tmo_bits <= 6'h00;
			else if (bit_tick && tmo_bits != tmo_limit) tmo_bits <= tmo_bits + 6'h01;
			if (tmo_set) tmo <= 1'b1;
			else if (rhr_rd) tmo <= 1'b0;
		end
	end

	// transmit ready: threshold crossing and empty; half-duplex waits for shifter
	assign tx_src = feature_control_reg[`URX_FEATURE_CONTROL_REG_RS485] ? (thr_empty && tsr_empty) : thr_empty;
	assign tx_set = (tx_src && !tx_prev) || (fifo_en && tx_below_trig && !below_prev);
	// modem deltas; trailing ring edge is high-to-low of the status
	assign delta_set = {ms_pin.cd_n ^ ms_prev.cd_n, ms_pin.ri_n && !ms_prev.ri_n,
		ms_pin.dsr_n ^ ms_prev.dsr_n, ms_pin.cts_n ^ ms_prev.cts_n};
	assign flow_set = enhanced_feature_reg[`URX_EFR_ENH] && ((interrupt_enable[7] && ms_pin.cts_n && !ms_prev.cts_n) ||
		(interrupt_enable[6] && rts_n && !rts_prev));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_prev <= 1'b0;
			below_prev <= 1'b0;
			txrdy <= 1'b0;
			ms_prev <= 4'hF;
			delta <= 4'h0;
			flow_f <= 1'b0;
			xoff_f <= 1'b0;
		end else if (pclken) begin
			tx_prev <= tx_src;
			below_prev <= tx_below_trig;
			ms_prev <= ms_pin;
			if (tx_set) txrdy <= 1'b1;
			else if (thr_wr || (isr_rd && cur_idx == 3'h3)) txrdy <= 1'b0;
			delta <= delta_set | (msr_rd ? 4'h0 : delta);
			if (flow_set) flow_f <= 1'b1;
			else if (msr_rd) flow_f <= 1'b0;
			if (xoff_seen) xoff_f <= 1'b1;
			else if (isr_rd && cur_idx == 3'h5) xoff_f <= 1'b0;
		end
	end

	// enabled sources in priority order
	assign pend = {flow_f && (interrupt_enable[7] || interrupt_enable[6]) && enhanced_feature_reg[`URX_EFR_ENH],
		xoff_f && interrupt_enable[5] && enhanced_feature_reg[`URX_EFR_ENH],
		(delta != 4'h0) && interrupt_enable[3],
		txrdy && interrupt_enable[1],
		tmo && interrupt_enable[0],
		rx_avail && interrupt_enable[0],
		lsr_int && interrupt_enable[2]};
	// the reported source stays until its own clearing action
	assign next_idx = (cur_idx == `URX_IDX_NONE || !pend[cur_idx]) ? pick(pend) : cur_idx;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_idx <= `URX_IDX_NONE;
			irq <= 1'b0;
		end else if (pclken) begin
			cur_idx <= next_idx;
			irq <= (next_idx != `URX_IDX_NONE);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_start_drop;
		pclken && state == URX_START && tick && os_cnt == half_last && rx_s |=> state == URX_IDLE;
	endproperty
	a_start_drop: assert property (p_start_drop) else $error("high start sample not discarded");
	property p_start_take;
		pclken && state == URX_START && tick && os_cnt == half_last && !rx_s |=> state == URX_DATA && bit_idx == 4'h0;
	endproperty
	a_start_take: assert property (p_start_take) else $error("low start sample not accepted");
	property p_ready_set;
		pclken && push_ok && !fifo_clr |=> lsr_val[0] && level == $past(level) + 7'h01 - {6'h00, $past(pop)};
	endproperty
	a_ready_set: assert property (p_ready_set) else $error("data ready not set on push");
	property p_pop_moves;
		pclken && pop && !push_ok && !fifo_clr |=> rd_ptr == $past(rd_ptr) + 6'h01 && level == $past(level) - 7'h01;
	endproperty
	a_pop_moves: assert property (p_pop_moves) else $error("holding read did not advance fifo");
	property p_head_only;
		(level == 7'h00 || !has_err(head)) |-> lsr_val[4:2] == 3'b000 && (lsr_val[7] == (err_cnt != 7'h00));
	endproperty
	a_head_only: assert property (p_head_only) else $error("error flags not of head");
	property p_lsr_clear;
		pclken && lsr_rd && !lsr_set |=> !lsr_int;
	endproperty
	a_lsr_clear: assert property (p_lsr_clear) else $error("line status read kept interrupt");
	property p_tmo_clear;
		pclken && rhr_rd && !tmo_set |=> !tmo;
	endproperty
	a_tmo_clear: assert property (p_tmo_clear) else $error("holding read kept time-out");
	property p_quiet;
		pclken && interrupt_enable == 8'h00 && cur_idx == `URX_IDX_NONE |=> !irq ##1 cur_idx == `URX_IDX_NONE || interrupt_enable != 8'h00;
	endproperty
	a_quiet: assert property (p_quiet) else $error("interrupt with all enables clear");
	property p_hold;
		pclken && cur_idx != `URX_IDX_NONE && pend[cur_idx] |=> cur_idx == $past(cur_idx);
	endproperty
	a_hold: assert property (p_hold) else $error("pending interrupt replaced before service");
	property p_div_lock;
		pclken && wr && !dlab |=> $stable(dll) && $stable(divisor_high_byte);
	endproperty
	a_div_lock: assert property (p_div_lock) else $error("divisor changed with latch bit clear");
endmodule

// File: design/urx_map.svh
// register indices, field positions, reset values and oversampling counts of one receive channel
`ifndef URX_MAP_SVH
`define URX_MAP_SVH
`define URX_IDX_RHR 4'h0
`define URX_IDX_IER 4'h1
`define URX_IDX_ISR 4'h2
`define URX_IDX_LCR 4'h3
`define URX_IDX_MCR 4'h4
`define URX_IDX_LSR 4'h5
`define URX_IDX_MSR 4'h6
`define URX_IDX_FEATURE_CONTROL_REG 4'h8
`define URX_IDX_EFR 4'h9
`define URX_IDX_RXCNT 4'hB
`define URX_IER_RESET 8'h00
`define URX_IER_WMASK 8'hEF
`define URX_LCR_RESET 8'h00
`define URX_REG_RESET 8'h00
`define URX_LCR_DLAB 7
`define URX_LCR_PAR_EN 3
`define URX_LCR_EVEN 4
`define URX_MCR_RTS 1
`define URX_MCR_OS8 7
`define URX_EFR_ENH 4
`define URX_FEATURE_CONTROL_REG_RS485 5
`define URX_FCR_EN 0
`define URX_FCR_RXCLR 1
`define URX_OS16_BIT 5'h10
`define URX_OS8_BIT 5'h08
`define URX_OS16_HALF 5'h08
`define URX_OS8_HALF 5'h04
`define URX_TMO_EXTRA 6'h0C
`define URX_WL_BASE 4'h5
`define URX_FIFO_CAP 7'h40
`define URX_NOFIFO_CAP 7'h01
`define URX_CODE_NONE 6'h01
`define URX_CODE_LSR 6'h06
`define URX_CODE_RXRDY 6'h04
`define URX_CODE_RXTMO 6'h0C
`define URX_CODE_TXRDY 6'h02
`define URX_CODE_MSR 6'h00
`define URX_CODE_XOFF 6'h10
`define URX_CODE_FLOW 6'h20
`define URX_IDX_NONE 3'h7
`endif

// File: design/urx_pkg.sv
// types shared by the receive channel modules
package urx_pkg;
	// receiver sequencer states
	typedef enum logic [2:0] {
		URX_IDLE,
		URX_START,
		URX_DATA,
		URX_PARITY,
		URX_STOP
	} urx_state_type;
	// one receive fifo entry: per-character error flags and data
	typedef struct packed {
		logic brk;
		logic frm;
		logic par;
		logic [7:0] data;
	} urx_rx_entry_type;
	// modem input pins, all active low
	typedef struct packed {
		logic cd_n;
		logic ri_n;
		logic dsr_n;
		logic cts_n;
	} urx_modem_type;
endpackage

// File: design/urx_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module urx_sync #(
	parameter int WIDTH = 5
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta; // first stage, read only by q
	// pins idle high; both stages reset to that level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= {WIDTH{1'b1}};
			q <= {WIDTH{1'b1}};
		end else if (ce) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// File: testbench/urx_line_model.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/10ps
module urx_line_model (
	input wire logic clk,
	output logic rx
);
	// line idles high between frames
	initial rx = 1'b1;
	// start, eight data bits lsb first, stop; bad_stop pulls the stop bit low
	task automatic send(input logic [7:0] d, input logic bad_stop);
		logic [9:0] f;
		f = {~bad_stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx <= f[i];
			repeat (16) @(posedge clk);
		end
		// one idle cycle so back-to-back frames never drive rx twice in one step
		rx <= 1'b1;
		@(posedge clk);
	endtask
	// low pulse far shorter than half a bit, must not start a character
	task automatic glitch();
		rx <= 1'b0;
		repeat (3) @(posedge clk);
		rx <= 1'b1;
	endtask
endmodule

// File: testbench/tb_top.sv
// self-checking bench for one receive channel over apb
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin failures++; \
	$display("mismatch %s expected %h seen %h", n, e, a); end end
module tb_top;
	logic pclk = 1'b0; // 100 MHz bus clock
	logic presetn = 1'b0; // active low reset
	logic pclken = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rx_pin;
	urx_pkg::urx_modem_type modem_pins_n = 4'hF; // modem pins idle high
	logic thr_empty = 1'b1;
	logic tsr_empty = 1'b1;
	logic tx_below_trig = 1'b0;
	logic xoff_seen = 1'b0;
	logic irq; // interrupt request seen from the channel
	logic rts_n; // request-to-send pin, active low
	logic [7:0] tx_data; // last byte handed to the transmitter
	logic last_err; // error response of the last access
	logic [7:0] q;
	int failures = 0;
	int checks_done = 0;
	// clock generator
	always #5 pclk = ~pclk;
	urx_channel dut (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_pin(rx_pin), .modem_pins_n(modem_pins_n), .thr_empty(thr_empty), .tsr_empty(tsr_empty),
		.tx_below_trig(tx_below_trig), .xoff_seen(xoff_seen), .rts_n(rts_n), .tx_write(), .tx_data(tx_data),
		.irq(irq));
	urx_line_model line (.clk(pclk), .rx(rx_pin));
	// one apb transfer; waits for pready, only the watchdog ends a hang
	task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] rd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {26'h0, idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		logic [7:0] dummy;
		apb(1'b1, idx, d, dummy);
	endtask
	task automatic rd_chk(input logic [3:0] idx, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] v;
		apb(1'b0, idx, 8'h00, v);
		`CHK($sformatf("register %h", idx), e, v & m)
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// watchdog: whole run is a few thousand cycles
	initial begin
		#200000;
		failures++;
		summarize();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rd_chk(4'h1, 8'h00, 8'hFF);
		rd_chk(4'h2, 8'h01, 8'hFF);
		wr(4'h1, 8'hFF);
		rd_chk(4'h1, 8'hEF, 8'hFF);
		wr(4'h1, 8'h05);
		wr(4'h3, 8'h03);
		apb(1'b0, 4'h7, 8'h00, q);
		`CHK("unmapped error", 1'b1, last_err)
		`CHK("unmapped data", 8'h00, q)
		$display("test registers done");
		line.glitch();
		repeat (48) @(posedge pclk);
		rd_chk(4'h5, 8'h60, 8'hFF);
		$display("test glitch done");
		line.send(8'hA5, 1'b0);
		repeat (4) @(posedge pclk);
		rd_chk(4'h2, 8'h04, 8'hFF);
		rd_chk(4'h5, 8'h61, 8'hFF);
		rd_chk(4'h0, 8'hA5, 8'hFF);
		rd_chk(4'h5, 8'h60, 8'hFF);
		rd_chk(4'h2, 8'h01, 8'hFF);
		$display("test good frame done");
		line.send(8'h55, 1'b1);
		repeat (20) @(posedge pclk);
		rd_chk(4'h2, 8'h06, 8'hFF);
		rd_chk(4'h5, 8'h09, 8'h1F);
		rd_chk(4'h2, 8'h04, 8'hFF);
		rd_chk(4'h0, 8'h55, 8'hFF);
		rd_chk(4'h5, 8'h60, 8'hFF);
		$display("test framing done");
		line.send(8'h11, 1'b0);
		line.send(8'h22, 1'b0);
		repeat (4) @(posedge pclk);
		rd_chk(4'h5, 8'h03, 8'h03);
		rd_chk(4'h0, 8'h11, 8'hFF);
		$display("test overrun done");
		wr(4'h2, 8'h41);
		wr(4'h1, 8'h00);
		line.send(8'h33, 1'b0);
		line.send(8'h44, 1'b0);
		repeat (4) @(posedge pclk);
		rd_chk(4'h5, 8'h61, 8'hFF);
		rd_chk(4'hB, 8'h02, 8'hFF);
		wr(4'h1, 8'h01);
		rd_chk(4'h2, 8'hC1, 8'hFF);
		repeat (800) @(posedge pclk);
		`CHK("irq", 1'b1, irq)
		rd_chk(4'h2, 8'hCC, 8'hFF);
		rd_chk(4'h0, 8'h33, 8'hFF);
		rd_chk(4'h2, 8'hC1, 8'hFF);
		`CHK("irq", 1'b0, irq)
		$display("test fifo time-out done");
		wr(4'h9, 8'h10);
		wr(4'h1, 8'h41);
		wr(4'h4, 8'h02);
		repeat (2) @(posedge pclk);
		`CHK("rts", 1'b0, rts_n)
		wr(4'h4, 8'h00);
		repeat (2) @(posedge pclk);
		rd_chk(4'h2, 8'hE0, 8'hFF);
		rd_chk(4'h6, 8'h00, 8'hFF);
		rd_chk(4'h2, 8'hC1, 8'hFF);
		wr(4'h0, 8'h5A);
		`CHK("tx data", 8'h5A, tx_data)
		$display("test flow done");
		summarize();
	end
endmodule
